// ---- src/dtr_map.svh ----
`ifndef DTR_MAP_SVH
`define DTR_MAP_SVH

// ----------------------------------------
// clock and guard timing
// ----------------------------------------
`define DTR_CLK_HZ      10000000
`define DTR_XTAL_HZ     3579500
`define DTR_GUARD_MS    20
`define DTR_ACCEPT_MS   40
`define DTR_GAP_MS      40

// ----------------------------------------
// tone groups and period qualification
// ----------------------------------------
`define DTR_LOW_F0      697
`define DTR_LOW_F1      770
`define DTR_LOW_F2      852
`define DTR_LOW_F3      941
`define DTR_HIGH_F0     1209
`define DTR_HIGH_F1     1336
`define DTR_HIGH_F2     1477
`define DTR_HIGH_F3     1633
`define DTR_TOL_PM      15
`define DTR_MATCHES     2
`define DTR_PERIOD_W    16

// ----------------------------------------
// register port map
// ----------------------------------------
`define DTR_REG_STATUS  4'h0
`define DTR_REG_IRQ_CLR 4'h1
`define DTR_REG_IRQ_EN  4'h2
`define DTR_REG_CTRL    4'h3
`define DTR_REG_STATE   4'h4
`define DTR_CTRL_RST    8'h01
`define DTR_IRQ_EN_RST  8'h00
`define DTR_EV_ACCEPT   0
`define DTR_EV_RELEASE  1
`define DTR_EV_REJECT   2
`define DTR_CTRL_ENABLE 0

`endif

// ---- src/dtr_pkg.sv ----
package dtr_pkg;

    typedef logic [3:0] dtr_code_t;
    typedef logic [1:0] dtr_idx_t;
    typedef logic [7:0] dtr_byte_t;
    typedef logic [3:0] dtr_addr_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_PRESENT,
        ST_VALID,
        ST_ABSENT,
        ST_HOLDOFF
    } dtr_state_t;

endpackage

// ---- src/dtr_freq_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// one tone group's classification result
interface dtr_freq_if;
    logic               valid;
    dtr_pkg::dtr_idx_t  idx;

    modport src (output valid, output idx);
    modport dst (input valid, input idx);
endinterface

`default_nettype wire

// ---- src/dtr_band_meter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtr_map.svh"

module dtr_band_meter
#(
    parameter int unsigned CLK_HZ = `DTR_CLK_HZ,
    parameter int unsigned F0     = `DTR_LOW_F0,
    parameter int unsigned F1     = `DTR_LOW_F1,
    parameter int unsigned F2     = `DTR_LOW_F2,
    parameter int unsigned F3     = `DTR_LOW_F3,
    parameter int unsigned CW     = `DTR_PERIOD_W
)
(
    // clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_reset,
    // comparator square wave
    input  wire logic  i_cmp,
    // classification
    dtr_freq_if.src    o_band
);
    import dtr_pkg::*;

    localparam int unsigned FREQ [4] = '{F0, F1, F2, F3};

    // period window in clock cycles, tolerance in per mille
    function automatic logic [CW-1:0] period_bound(input int unsigned f, input bit upper);
        longint unsigned num;
        longint unsigned den;
        num = 64'(CLK_HZ) * 64'd1000;
        den = 64'(f) * (upper ? 64'(1000 - `DTR_TOL_PM) : 64'(1000 + `DTR_TOL_PM));
        return CW'(num / den);
    endfunction

    logic           cmp_d;
    logic [CW-1:0]  per_cnt;
    dtr_idx_t       last_bin;
    logic [1:0]     match_cnt;
    logic           valid;
    logic           edge_seen;
    logic           hit;
    dtr_idx_t       bin;

    assign edge_seen = i_cmp & ~cmp_d;

    always_comb
    begin
        hit = 1'b0;
        bin = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (per_cnt >= period_bound(FREQ[i], 1'b0) && per_cnt <= period_bound(FREQ[i], 1'b1))
            begin
                hit = 1'b1;
                bin = 2'(i);
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cmp_d   <= 1'b0;
            per_cnt <= '0;
        end
        else
        begin
            cmp_d   <= i_cmp;
            per_cnt <= edge_seen ? CW'(1) : (&per_cnt ? per_cnt : per_cnt + CW'(1));
        end
    end

    // a tone counts once several consecutive periods land in the same bin
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            last_bin  <= '0;
            match_cnt <= '0;
            valid     <= 1'b0;
        end
        else if (per_cnt > period_bound(FREQ[0], 1'b1))
        begin
            match_cnt <= '0;
            valid     <= 1'b0;
        end
        else if (edge_seen)
        begin
            last_bin  <= bin;
            match_cnt <= (!hit || bin != last_bin) ? 2'd0 : (match_cnt == 2'(`DTR_MATCHES) ? match_cnt : match_cnt + 2'd1);
            valid     <= hit && bin == last_bin && match_cnt >= 2'(`DTR_MATCHES - 1);
        end
    end

    assign o_band.valid = valid;
    assign o_band.idx   = last_bin;

endmodule

`default_nettype wire

// ---- src/dtr_tone_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtr_map.svh"

module dtr_tone_decoder
#(
    parameter int unsigned CLK_HZ      = `DTR_CLK_HZ,
    parameter int unsigned GTP_CYCLES  = `DTR_GUARD_MS * (`DTR_CLK_HZ / 1000),
    parameter int unsigned GTA_CYCLES  = `DTR_GUARD_MS * (`DTR_CLK_HZ / 1000),
    parameter int unsigned QUAL_CYCLES = (`DTR_ACCEPT_MS - `DTR_GUARD_MS) * (`DTR_CLK_HZ / 1000),
    parameter int unsigned GAP_CYCLES  = `DTR_GAP_MS * (`DTR_CLK_HZ / 1000)
)
(
    // clock and reset
    input  wire logic           i_mclk,
    input  wire logic           i_reset,
    // filter comparators and test strap
    input  wire logic           i_low_cmp,
    input  wire logic           i_high_cmp,
    input  wire logic           i_test_select,
    // code bus
    input  wire logic           i_output_enable,
    output var  dtr_pkg::dtr_code_t o_code_out,
    output var  logic           o_code_oe_n,
    // status pins
    output var  logic           o_freq_detect_flag,
    output var  logic           o_tone_valid_strobe,
    output var  logic           o_guard_status_out,
    output var  logic           o_crystal_out,
    // register port
    input  wire dtr_pkg::dtr_addr_t i_addr,
    input  wire dtr_pkg::dtr_byte_t i_wdata,
    input  wire logic           i_wr,
    input  wire logic           i_rd,
    output var  dtr_pkg::dtr_byte_t o_rdata,
    // interrupt
    output var  logic           o_irq
);
    import dtr_pkg::*;

    localparam int unsigned GW = $clog2(GAP_CYCLES + QUAL_CYCLES + 2) + 1;
    localparam int unsigned HOLD_CYCLES = GAP_CYCLES - GTA_CYCLES;

    // ----------------------------------------
    // pair to code table
    // ----------------------------------------
    function automatic dtr_code_t pair_code(input dtr_idx_t row, input dtr_idx_t col);
        case ({row, col})
            4'h0:    return 4'h1;
            4'h1:    return 4'h2;
            4'h2:    return 4'h3;
            4'h3:    return 4'hd;
            4'h4:    return 4'h4;
            4'h5:    return 4'h5;
            4'h6:    return 4'h6;
            4'h7:    return 4'he;
            4'h8:    return 4'h7;
            4'h9:    return 4'h8;
            4'ha:    return 4'h9;
            4'hb:    return 4'hf;
            4'hc:    return 4'hb;
            4'hd:    return 4'ha;
            4'he:    return 4'hc;
            default: return 4'h0;
        endcase
    endfunction

    // ----------------------------------------
    // group classifiers
    // ----------------------------------------
    dtr_freq_if low_band ();
    dtr_freq_if high_band ();

    dtr_band_meter
    #(.CLK_HZ(CLK_HZ), .F0(`DTR_LOW_F0), .F1(`DTR_LOW_F1),
      .F2(`DTR_LOW_F2), .F3(`DTR_LOW_F3), .CW(`DTR_PERIOD_W))
    u_low
    (.i_mclk(i_mclk), .i_reset(i_reset), .i_cmp(i_low_cmp), .o_band(low_band.src));

    dtr_band_meter
    #(.CLK_HZ(CLK_HZ), .F0(`DTR_HIGH_F0), .F1(`DTR_HIGH_F1),
      .F2(`DTR_HIGH_F2), .F3(`DTR_HIGH_F3), .CW(`DTR_PERIOD_W))
    u_high
    (.i_mclk(i_mclk), .i_reset(i_reset), .i_cmp(i_high_cmp), .o_band(high_band.src));

    // ----------------------------------------
    // signals
    // ----------------------------------------
    dtr_byte_t   ctrl;
    dtr_byte_t   irq_en;
    dtr_byte_t   status;
    dtr_byte_t   next_status;
    logic [2:0]  ev;
    logic        pair_ok;
    dtr_code_t   cur_code;
    dtr_code_t   cand_code;
    logic [GW-1:0] qual_cnt;
    logic [GW-1:0] gcnt;
    dtr_state_t  state;
    logic        flag_d;

    assign pair_ok  = low_band.valid & high_band.valid & ctrl[`DTR_CTRL_ENABLE];
    assign cur_code = pair_code(low_band.idx, high_band.idx);

    // ----------------------------------------
    // frequency qualification
    // ----------------------------------------
    // the pair must hold one code throughout; a change restarts the count
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cand_code <= '0;
            qual_cnt  <= '0;
        end
        else if (!pair_ok || cur_code != cand_code)
        begin
            cand_code <= cur_code;
            qual_cnt  <= '0;
        end
        else if (qual_cnt != GW'(QUAL_CYCLES - 1))
        begin
            qual_cnt  <= qual_cnt + GW'(1);
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_freq_detect_flag <= 1'b0;
            flag_d             <= 1'b0;
        end
        else
        begin
            // falls the cycle after the pair is lost
            o_freq_detect_flag <= pair_ok && cur_code == cand_code
                                  && qual_cnt == GW'(QUAL_CYCLES - 1);
            flag_d             <= o_freq_detect_flag;
        end
    end

    // ----------------------------------------
    // guard timing
    // ----------------------------------------
    // counts are fixed at build time; software has no say over them
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            state               <= ST_IDLE;
            gcnt                <= '0;
            o_tone_valid_strobe <= 1'b0;
            o_code_out          <= '0;
            ev                  <= '0;
        end
        else
        begin
            ev <= '0;
            case (state)
                ST_IDLE:
                begin
                    gcnt <= '0;
                    if (o_freq_detect_flag)
                        state <= ST_PRESENT;
                end
                ST_PRESENT:
                begin
                    if (!o_freq_detect_flag)
                        state <= ST_IDLE;
                    else if (gcnt == GW'(GTP_CYCLES - 1))
                    begin
                        state               <= ST_VALID;
                        o_tone_valid_strobe <= 1'b1;
                        o_code_out          <= cand_code;
                        ev[`DTR_EV_ACCEPT]  <= 1'b1;
                    end
                    else
                        gcnt <= gcnt + GW'(1);
                end
                ST_VALID:
                begin
                    gcnt <= '0;
                    if (!o_freq_detect_flag)
                        state <= ST_ABSENT;
                end
                ST_ABSENT:
                begin
                    // a short dropout is bridged, even if the pair came back different
                    if (o_freq_detect_flag)
                    begin
                        state <= ST_VALID;
                        if (cand_code != o_code_out)
                            ev[`DTR_EV_REJECT] <= 1'b1;
                    end
                    else if (gcnt == GW'(GTA_CYCLES - 1))
                    begin
                        state               <= ST_HOLDOFF;
                        gcnt                <= '0;
                        o_tone_valid_strobe <= 1'b0;
                        ev[`DTR_EV_RELEASE] <= 1'b1;
                    end
                    else
                        gcnt <= gcnt + GW'(1);
                end
                ST_HOLDOFF:
                begin
                    // silence must be continuous; a tone here restarts the gap
                    if (o_freq_detect_flag)
                    begin
                        gcnt <= '0;
                        if (!flag_d)
                            ev[`DTR_EV_REJECT] <= 1'b1;
                    end
                    else if (gcnt == GW'(HOLD_CYCLES - 1))
                        state <= ST_IDLE;
                    else
                        gcnt <= gcnt + GW'(1);
                end
                default:
                begin
                    state <= ST_IDLE;
                    gcnt  <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    // enable lags the pin by one clock so the output stays a flop
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_code_oe_n        <= 1'b1;
            o_guard_status_out <= 1'b1;
            o_crystal_out      <= 1'b0;
        end
        else
        begin
            o_code_oe_n        <= ~i_output_enable;
            o_guard_status_out <= 1'b1;
            o_crystal_out      <= ~o_crystal_out;
        end
    end

    // ----------------------------------------
    // registers and interrupt
    // ----------------------------------------
    always_comb
    begin
        next_status = status;
        if (i_wr && i_addr == `DTR_REG_IRQ_CLR)
            next_status = status & ~i_wdata;
        next_status[2:0] = next_status[2:0] | ev;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            status <= '0;
            irq_en <= `DTR_IRQ_EN_RST;
            ctrl   <= `DTR_CTRL_RST;
            o_irq  <= 1'b0;
        end
        else
        begin
            status <= next_status;
            if (i_wr && i_addr == `DTR_REG_IRQ_EN)
                irq_en <= i_wdata;
            if (i_wr && i_addr == `DTR_REG_CTRL)
                ctrl <= i_wdata;
            o_irq <= |(next_status & (i_wr && i_addr == `DTR_REG_IRQ_EN ? i_wdata : irq_en));
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
            o_rdata <= '0;
        else if (!i_rd)
            o_rdata <= '0;
        else
        begin
            case (i_addr)
                `DTR_REG_STATUS: o_rdata <= status;
                `DTR_REG_IRQ_EN: o_rdata <= irq_en;
                `DTR_REG_CTRL:   o_rdata <= ctrl;
                `DTR_REG_STATE:  o_rdata <= {1'b0, i_test_select, o_freq_detect_flag,
                                             o_tone_valid_strobe, o_code_out};
                default:         o_rdata <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [GW-1:0] flag_run;
    logic [GW-1:0] low_run;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            flag_run <= '0;
            low_run  <= '0;
        end
        else
        begin
            flag_run <= !o_freq_detect_flag ? '0 : (&flag_run ? flag_run : flag_run + GW'(1));
            low_run  <= o_freq_detect_flag ? '0 : (&low_run ? low_run : low_run + GW'(1));
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    a_code_with_strobe: assert property ($rose(o_tone_valid_strobe) |-> o_code_out == $past(cand_code))
        else $error("code not updated with strobe");
    a_code_held: assert property (o_tone_valid_strobe && $past(o_tone_valid_strobe) |-> $stable(o_code_out))
        else $error("code changed while strobe high");
    a_oe_follows: assert property (##1 o_code_oe_n == !$past(i_output_enable))
        else $error("output enable not followed");
    a_guard_high: assert property (o_guard_status_out)
        else $error("guard status low");
    a_flag_drops: assert property (!pair_ok |=> !o_freq_detect_flag)
        else $error("flag held without valid pair");
    a_flag_qualified: assert property ($rose(o_freq_detect_flag) |-> $past(qual_cnt) == GW'(QUAL_CYCLES - 1))
        else $error("flag rose before qualification");
    a_strobe_after_gtp: assert property ($rose(o_tone_valid_strobe) |-> flag_run > GW'(GTP_CYCLES))
        else $error("strobe rose before present guard");
    a_strobe_after_gta: assert property ($fell(o_tone_valid_strobe) |-> low_run > GW'(GTA_CYCLES))
        else $error("strobe fell before absent guard");
    a_strobe_needs_flag: assert property ($rose(o_tone_valid_strobe) |-> $past(o_freq_detect_flag))
        else $error("strobe without detected pair");

endmodule

`default_nettype wire

// ---- test/dtr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module dtr_host_model
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    // decoder side
    input  wire logic       i_strobe,
    input  wire logic [3:0] i_code_pin,
    output var  logic       o_output_enable,
    output var  logic       o_test_select,
    // captured digits
    output var  logic [3:0] o_last_code,
    output var  logic [7:0] o_reads
);
    logic strobe_q;
    logic en_age;

    assign o_test_select = 1'b0;

    // the pins are only trusted one cycle after the enable has turned the drivers on
    always_ff @(posedge i_mclk)
    begin
        strobe_q <= i_strobe;
        if (i_reset)
        begin
            o_output_enable <= 1'b0;
            en_age          <= 1'b0;
            o_reads         <= 8'h00;
            o_last_code     <= 4'h0;
        end
        else if (i_strobe && !strobe_q)
        begin
            o_output_enable <= 1'b1;
            en_age          <= 1'b0;
        end
        else if (o_output_enable && !en_age)
            en_age <= 1'b1;
        else if (o_output_enable)
        begin
            o_last_code     <= i_code_pin;
            o_reads         <= o_reads + 8'h01;
            o_output_enable <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ---- test/dtr_tone_decoder_output_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtr_map.svh"

module dtr_tone_decoder_output_tb;
    import dtr_pkg::*;

    // --------------------------------
    // shortened timing
    // --------------------------------
    localparam int unsigned CLK_HZ = 500000;
    localparam int unsigned PRESENT_GUARD_TIME    = 20;
    localparam int unsigned ABSENT_GUARD_TIME    = 40;
    localparam int unsigned QUAL   = 20;
    localparam int unsigned GAP    = 200;
    localparam int LOW_F[4]  = '{`DTR_LOW_F0, `DTR_LOW_F1, `DTR_LOW_F2, `DTR_LOW_F3};
    localparam int HIGH_F[4] = '{`DTR_HIGH_F0, `DTR_HIGH_F1, `DTR_HIGH_F2, `DTR_HIGH_F3};
    localparam dtr_code_t CODE[16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
                                       4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};

    logic      mclk     = 1'b0;
    logic      reset    = 1'b1;
    logic      low_cmp  = 1'b0;
    logic      high_cmp = 1'b0;
    logic      wr       = 1'b0;
    logic      rd       = 1'b0;
    dtr_addr_t addr     = 4'h0;
    dtr_byte_t wdata    = 8'h00;
    wire logic oe, test_sel, flag, strobe, oe_n, guard, xtal_out, irq;
    wire dtr_code_t code, code_pin, host_code;
    wire dtr_byte_t rdata, host_reads;
    int failures = 0;
    int checks   = 0;
    int cyc      = 0;
    int lo_half  = 0;
    int hi_half  = 0;
    int lo_cnt   = 0;
    int hi_cnt   = 0;
    int t_fr     = 0;
    int t_ff     = 0;
    logic flag_q, strobe_q;
    dtr_code_t code_q;
    dtr_code_t exp_code = 4'h0;

    // released pins show the inverse, so a stale read cannot pass
    assign code_pin = (oe_n === 1'b0) ? code : ~code;

    dtr_tone_decoder #(.CLK_HZ(CLK_HZ), .GTP_CYCLES(PRESENT_GUARD_TIME), .GTA_CYCLES(ABSENT_GUARD_TIME), .QUAL_CYCLES(QUAL),
                       .GAP_CYCLES(GAP)) dut
    (
        .i_mclk(mclk), .i_reset(reset), .i_low_cmp(low_cmp), .i_high_cmp(high_cmp),
        .i_test_select(test_sel), .i_output_enable(oe), .o_code_out(code), .o_code_oe_n(oe_n),
        .o_freq_detect_flag(flag), .o_tone_valid_strobe(strobe), .o_guard_status_out(guard),
        .o_crystal_out(xtal_out), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_irq(irq)
    );

    dtr_host_model host
    (
        .i_mclk(mclk), .i_reset(reset), .i_strobe(strobe), .i_code_pin(code_pin),
        .o_output_enable(oe), .o_test_select(test_sel), .o_last_code(host_code), .o_reads(host_reads)
    );

    always #50 mclk = ~mclk;

    // --------------------------------
    // comparator square waves
    // --------------------------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        lo_cnt <= (lo_half == 0 || lo_cnt >= lo_half - 1) ? 0 : lo_cnt + 1;
        hi_cnt <= (hi_half == 0 || hi_cnt >= hi_half - 1) ? 0 : hi_cnt + 1;
        if (lo_half == 0)
            low_cmp <= 1'b0;
        else if (lo_cnt >= lo_half - 1)
            low_cmp <= ~low_cmp;
        if (hi_half == 0)
            high_cmp <= 1'b0;
        else if (hi_cnt >= hi_half - 1)
            high_cmp <= ~high_cmp;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // edge timing of flag, strobe and code
    always @(posedge mclk)
    begin
        flag_q   <= flag;
        strobe_q <= strobe;
        code_q   <= code;
        if (!reset)
        begin
            if (flag && !flag_q)
                t_fr = cyc;
            if (!flag && flag_q)
                t_ff = cyc;
            if (strobe && !strobe_q)
            begin
                chk(cyc - t_fr, PRESENT_GUARD_TIME + 1);
                chk(code, exp_code);
            end
            if (!strobe && strobe_q)
                chk(cyc - t_ff, ABSENT_GUARD_TIME + 1);
            if (code !== code_q && !(strobe && !strobe_q))
                chk(code, code_q);
        end
    end

    task automatic reg_wr(input dtr_addr_t a, input dtr_byte_t d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input dtr_addr_t a, input dtr_byte_t exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic tone_on(input int r, input int c);
        exp_code = CODE[r * 4 + c];
        lo_half  = CLK_HZ / (2 * LOW_F[r]);
        hi_half  = CLK_HZ / (2 * HIGH_F[c]);
    endtask

    task automatic wait_strobe(input logic lvl, input int n);
        int i;
        for (i = 0; i < n && strobe !== lvl; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk(strobe, lvl);
    endtask

    task automatic run_digit(input int r, input int c);
        tone_on(r, c);
        wait_strobe(1'b1, 4000);
        chk(flag, 1'b1);
        chk(guard, 1'b1);
        repeat (4) @(posedge mclk);
        #1;
        chk(host_code, exp_code);
        lo_half = 0;
        hi_half = 0;
        wait_strobe(1'b0, 3000);
        chk(flag, 1'b0);
        chk(code, exp_code);
        repeat (GAP) @(posedge mclk);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic scn_reset();
        logic x0;
        chk({oe_n, flag, strobe, guard, irq, code}, 9'h120);
        x0 = xtal_out;
        @(posedge mclk);
        #1;
        chk(xtal_out, !x0);
        reg_rd(`DTR_REG_CTRL, 8'h01);
        reg_rd(`DTR_REG_IRQ_EN, 8'h00);
        reg_rd(`DTR_REG_STATUS, 8'h00);
        reg_rd(`DTR_REG_IRQ_CLR, 8'h00);
        reg_rd(4'h9, 8'h00);
    endtask

    task automatic scn_all_digits();
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 4; c++)
                run_digit(r, c);
        chk(host_reads, 8'h10);
    endtask

    task automatic scn_irq();
        reg_wr(`DTR_REG_IRQ_CLR, 8'h07);
        reg_rd(`DTR_REG_STATUS, 8'h00);
        reg_wr(`DTR_REG_IRQ_EN, 8'h01);
        reg_rd(`DTR_REG_IRQ_EN, 8'h01);
        chk(irq, 1'b0);
        run_digit(0, 0);
        reg_rd(`DTR_REG_STATUS, 8'h03);
        reg_rd(`DTR_REG_STATE, 8'h01);
        chk(irq, 1'b1);
        reg_wr(`DTR_REG_IRQ_EN, 8'h00);
        reg_wr(`DTR_REG_STATUS, 8'h00);
        reg_rd(`DTR_REG_STATUS, 8'h03);
        chk(irq, 1'b0);
        reg_wr(`DTR_REG_IRQ_EN, 8'h02);
        reg_rd(`DTR_REG_IRQ_EN, 8'h02);
        chk(irq, 1'b1);
        reg_wr(`DTR_REG_IRQ_CLR, 8'h02);
        reg_rd(`DTR_REG_STATUS, 8'h01);
        chk(irq, 1'b0);
        reg_wr(`DTR_REG_IRQ_CLR, 8'h01);
    endtask

    // short dropout is bridged; a tone back inside the gap is rejected, one after it is taken
    task automatic scn_gap();
        tone_on(1, 1);
        wait_strobe(1'b1, 4000);
        reg_wr(`DTR_REG_CTRL, 8'h00);
        reg_wr(`DTR_REG_CTRL, 8'h01);
        repeat (ABSENT_GUARD_TIME + 10) @(posedge mclk);
        #1;
        chk({flag, strobe}, 2'b11);
        reg_wr(`DTR_REG_CTRL, 8'h00);
        reg_rd(`DTR_REG_CTRL, 8'h00);
        chk(flag, 1'b0);
        wait_strobe(1'b0, 100);
        reg_wr(`DTR_REG_CTRL, 8'h01);
        repeat (GAP - ABSENT_GUARD_TIME - 30) @(posedge mclk);
        #1;
        chk({flag, strobe}, 2'b10);
        reg_rd(`DTR_REG_STATUS, 8'h07);
        lo_half = 0;
        hi_half = 0;
        repeat (4 * GAP) @(posedge mclk);
        #1;
        chk({flag, strobe}, 2'b00);
        run_digit(2, 2);
        reg_wr(`DTR_REG_IRQ_CLR, 8'h07);
    endtask

    task automatic conclude();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        scn_reset();
        scn_all_digits();
        scn_irq();
        scn_gap();
        conclude();
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        failures++;
        conclude();
    end
endmodule

`default_nettype wire
